/* src/ioexp_pkg.sv */
// Shared constants, register layout and state codes for the two-wire I/O expander.
package ioexp_pkg;

  // Command byte codes that select a register or a one-shot action.
  localparam logic [7:0] CMD_NORMAL_DRIVE  = 8'h00;
  localparam logic [7:0] CMD_NORMAL_RISE   = 8'h01;
  localparam logic [7:0] CMD_NORMAL_FALL   = 8'h02;
  localparam logic [7:0] CMD_SUSPEND_DRIVE = 8'h03;
  localparam logic [7:0] CMD_SUSPEND_RISE  = 8'h04;
  localparam logic [7:0] CMD_SUSPEND_FALL  = 8'h05;
  localparam logic [7:0] CMD_READBACK      = 8'h06;
  localparam logic [7:0] CMD_RESAMPLE_ADDR = 8'h07;
  localparam logic [7:0] CMD_SOFT_RESET    = 8'h08;
  localparam logic [7:0] CMD_MAKER_ID      = 8'hfe;

  // Power-on values of the register file.
  localparam logic [7:0] DRIVE_RESET_LOW = 8'h00;
  localparam logic [7:0] DRIVE_RESET_HIZ = 8'hff;
  localparam logic [7:0] MASK_RESET      = 8'hff;
  localparam logic [7:0] POINTER_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;

  // Bus bit meanings.
  localparam logic       DIR_READ            = 1'b1;
  localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h19;
  localparam logic [3:0] BITS_PER_BYTE       = 4'h8;

  // Three-level address strap codes and slave address building blocks.
  localparam logic [1:0] STRAP_GND   = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_VCC   = 2'h2;
  localparam logic [3:0] ADDR_HI_LOW_GND   = 4'h2;
  localparam logic [3:0] ADDR_HI_LOW_FLOAT = 4'hc;
  localparam logic [3:0] ADDR_HI_LOW_VCC   = 4'h7;
  localparam logic [3:0] ADDR_HI_HIZ_GND   = 4'h4;
  localparam logic [3:0] ADDR_HI_HIZ_FLOAT = 4'hd;
  localparam logic [3:0] ADDR_HI_HIZ_VCC   = 4'h6;
  localparam logic [2:0] ADDR_LO_BASE      = 3'h4;
  localparam logic [1:0] SAMPLE_DELAY      = 2'h3;

  // One complete register set: drive plus the two edge masks.
  typedef struct packed {
    logic [7:0] drive;
    logic [7:0] rise_mask;
    logic [7:0] fall_mask;
  } regset_t;

  // Bus slave states.
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ADDR      = 4'b0001,
    ST_ADDR_ACK  = 4'b0010,
    ST_CMD       = 4'b0011,
    ST_CMD_ACK   = 4'b0100,
    ST_WDATA     = 4'b0101,
    ST_WDATA_ACK = 4'b0110,
    ST_TX        = 4'b0111,
    ST_TX_ACK    = 4'b1000,
    ST_IGNORE    = 4'b1001
  } slave_state_t;

endpackage : ioexp_pkg

/* src/smbus_io_expander_regs.sv */
// Two-wire slave, dual register sets and pin control of the eight-pin I/O expander.
//
// How it works
// - Seven data registers: three normal, three suspend, one read-only pin readback.
// - Suspend-select high applies the normal set; low applies the suspend set.
// - Each drive bit either pulls its pin low or releases it.
// - Drive registers reset all-low or all-released, chosen by a build parameter.
// - Active rise mask gates rising-edge alerts; fall mask gates falling-edge alerts.
// - All mask bits come up masked after power-up.
// - Readback returns sampled pin levels, not drive register contents.
// - Read-byte samples pins at the end of the third byte acknowledge.
// - Receive-byte samples pins at the end of the first byte acknowledge.
// - Write to a read-only register lands in the normal drive register.
// - Bytes travel most significant bit first; bit 7 belongs to pin 7.
// - Write-byte is start, address, ack, command, ack, data, ack, stop.
// - Direction bit 0 writes, 1 reads; ack is 0, not-ack is 1.
// - Receive-byte returns last selected register, or own address on alert response.
// - Send-byte carries address and command only, acting as one-shot.
// - Resample command re-reads the address straps and adopts the new address.
// - Resample inside read or write still samples; written data goes to normal drive.
// - Soft-reset command resamples straps and restores power-on register values.
// - Soft-reset inside read or write still resets; data goes to normal drive.
// - Maker identification register is returned by a read-byte.
// - Write aimed at the identification register lands in normal drive.
// - Commands 00h-05h registers, 06h readback, 07h resample, 08h reset, FEh id.
// - Drive bit 0 pulls the pin low, 1 leaves it released.
// - Mask bit 0 lets the edge alert, 1 masks it.
// - Pointer starts at zero; soft reset leaves it unchanged.
`timescale 1ns/10ps
`default_nettype none

module smbus_io_expander_regs
  import ioexp_pkg::*;
#(
  parameter bit         RESET_RELEASED = 1'b0,  // Variant: pins released at power-up.
  parameter logic [7:0] MAKER_ID       = 8'h5a  // Arbitrary identification value.
) (
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  input  wire logic       SMB_CLK,
  input  wire logic       SMB_DATA_IN,
  output logic            SMB_DATA_OUT,
  output logic            SMB_DATA_OE,
  input  wire logic [7:0] IO_IN,
  output logic      [7:0] IO_OUT,
  output logic      [7:0] IO_OE,
  input  wire logic       SUSPEND_SELECT,
  input  wire logic [1:0] ADDR_STRAP0,
  input  wire logic [1:0] ADDR_STRAP1,
  output logic            ALERT_N_OUT,
  output logic            ALERT_N_OE
);

  localparam logic [7:0] DRIVE_RESET = RESET_RELEASED ? DRIVE_RESET_HIZ : DRIVE_RESET_LOW;
  localparam regset_t    SET_RESET   = '{drive: DRIVE_RESET, rise_mask: MASK_RESET,
                                         fall_mask: MASK_RESET};

  logic         scl_s1, scl_s2, scl_s3;
  logic         sda_s1, sda_s2, sda_s3;
  logic         sus_s1, sus_s2;
  logic [7:0]   io_s1, io_s2, io_s3;
  logic [1:0]   strap0_s1, strap0_s2, strap1_s1, strap1_s2;
  slave_state_t state_q, state_d;
  logic [3:0]   cnt_q;
  logic [7:0]   shift_q;
  logic         dir_q;
  logic         alert_resp_q;
  logic         sda_oe_q;
  logic [7:0]   pointer_q;
  logic         pend_rap_q, pend_reset_q;
  logic [1:0]   samp_cnt_q;
  logic [6:0]   own_addr_q;
  regset_t      normal_q, suspend_q;
  logic [7:0]   readback_q;
  logic         alert_q;

  // Input synchronisers; every pin crosses two flops before use.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
      {sus_s1, sus_s2}         <= 2'h3;
      {io_s1, io_s2, io_s3}    <= 24'h000000;
      {strap0_s1, strap0_s2}   <= 4'h0;
      {strap1_s1, strap1_s2}   <= 4'h0;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {SMB_CLK, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {SMB_DATA_IN, sda_s1, sda_s2};
      {sus_s1, sus_s2}         <= {SUSPEND_SELECT, sus_s1};
      {io_s1, io_s2, io_s3}    <= {IO_IN, io_s1, io_s2};
      {strap0_s1, strap0_s2}   <= {ADDR_STRAP0, strap0_s1};
      {strap1_s1, strap1_s2}   <= {ADDR_STRAP1, strap1_s1};
    end
  end

  // Bus events seen on the synchronised lines.
  wire scl_rise  = scl_s2 & ~scl_s3;
  wire scl_fall  = ~scl_s2 & scl_s3;
  wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_det  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire byte_done = (cnt_q == BITS_PER_BYTE);

  // Address byte decode: own address, or alert response while an alert is pending.
  wire addr_hit = (shift_q[7:1] == own_addr_q);
  wire ar_hit   = (shift_q[7:1] == ALERT_RESPONSE_ADDR) & (shift_q[0] == DIR_READ) & alert_q;
  wire addr_ack = addr_hit | ar_hit;

  // Falling edges that close each acknowledge; register updates happen here.
  wire addr_ack_end = (state_q == ST_ADDR_ACK) & scl_fall;
  wire read_start   = addr_ack_end & (dir_q == DIR_READ);
  wire cmd_ack_end  = (state_q == ST_CMD_ACK) & scl_fall;
  wire data_ack_end = (state_q == ST_WDATA_ACK) & scl_fall;

  // A pending one-shot command fires at the end of a send-byte, at a repeated
  // start of a read-byte, or with the data byte of a write-byte.
  wire cmd_fire  = (state_q == ST_WDATA) & (start_det | stop_det) | data_ack_end;
  wire fire_rap  = cmd_fire & pend_rap_q;
  wire fire_rst  = cmd_fire & pend_reset_q;

  // Slave address from the three-level straps, per device variant.
  wire [3:0] addr_hi_low = (strap0_s2 == STRAP_GND)   ? ADDR_HI_LOW_GND :
                           (strap0_s2 == STRAP_FLOAT) ? ADDR_HI_LOW_FLOAT : ADDR_HI_LOW_VCC;
  wire [3:0] addr_hi_hiz = (strap0_s2 == STRAP_GND)   ? ADDR_HI_HIZ_GND :
                           (strap0_s2 == STRAP_FLOAT) ? ADDR_HI_HIZ_FLOAT : ADDR_HI_HIZ_VCC;
  wire [2:0] addr_lo     = ((strap0_s2 == STRAP_VCC) ? 3'h0 : ADDR_LO_BASE) + {1'b0, strap1_s2};
  wire [6:0] addr_calc   = {RESET_RELEASED ? addr_hi_hiz : addr_hi_low, addr_lo};

  // Register read mux; the readback path shows live pins at the sampling edge.
  // identification read
  wire [7:0] reg_rd = (pointer_q == CMD_NORMAL_DRIVE)  ? normal_q.drive :
                      (pointer_q == CMD_NORMAL_RISE)   ? normal_q.rise_mask :
                      (pointer_q == CMD_NORMAL_FALL)   ? normal_q.fall_mask :
                      (pointer_q == CMD_SUSPEND_DRIVE) ? suspend_q.drive :
                      (pointer_q == CMD_SUSPEND_RISE)  ? suspend_q.rise_mask :
                      (pointer_q == CMD_SUSPEND_FALL)  ? suspend_q.fall_mask :
                      (pointer_q == CMD_READBACK)      ? io_s2 :
                      (pointer_q == CMD_MAKER_ID)      ? MAKER_ID : UNMAPPED_READ;
  wire [7:0] tx_byte = alert_resp_q ? {own_addr_q, 1'b0} : reg_rd;

  // Applied register set follows the synchronised suspend level directly.
  // select set
  wire     normal_active = sus_s2;
  regset_t act_set;
  assign act_set = normal_active ? normal_q : suspend_q;

  // Edge events gated by the active masks.
  wire [7:0] io_rise = io_s2 & ~io_s3 & ~act_set.rise_mask;
  wire [7:0] io_fall = ~io_s2 & io_s3 & ~act_set.fall_mask;

  // Next-state logic of the bus slave.
  // frame order
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE, ST_IGNORE: state_d = state_q;
      ST_ADDR: begin
        if (scl_fall && byte_done) begin
          state_d = addr_ack ? ST_ADDR_ACK : ST_IGNORE;
        end
      end
      ST_ADDR_ACK: begin
        if (scl_fall) begin
          state_d = (dir_q == DIR_READ) ? ST_TX : ST_CMD;
        end
      end
      ST_CMD: begin
        if (scl_fall && byte_done) begin
          state_d = ST_CMD_ACK;
        end
      end
      ST_CMD_ACK: begin
        if (scl_fall) begin
          state_d = ST_WDATA;
        end
      end
      ST_WDATA: begin
        if (scl_fall && byte_done) begin
          state_d = ST_WDATA_ACK;
        end
      end
      ST_WDATA_ACK, ST_TX_ACK: begin
        if (scl_fall) begin
          state_d = ST_IGNORE;
        end
      end
      ST_TX: begin
        if (scl_fall && byte_done) begin
          state_d = ST_TX_ACK;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (start_det) begin
      state_d = ST_ADDR;
    end else if (stop_det) begin
      state_d = ST_IDLE;
    end
  end

  // State, bit counter and shift register of the slave.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (start_det || stop_det || (scl_fall && state_d != state_q)) begin
        cnt_q <= 4'h0;
      end else if (scl_rise) begin
        cnt_q <= cnt_q + 4'h1;
      end
      if (read_start) begin
        shift_q <= tx_byte;
      end else if (state_q == ST_TX && scl_fall) begin
        shift_q <= {shift_q[6:0], 1'b0};
      end else if (scl_rise && state_q inside {ST_ADDR, ST_CMD, ST_WDATA}) begin
        shift_q <= {shift_q[6:0], sda_s2};
      end
    end
  end

  // Data line drive: acknowledges pull low, transmit pulls low for zero bits.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sda_oe_q     <= 1'b0;
      dir_q        <= 1'b0;
      alert_resp_q <= 1'b0;
    end else begin
      if (state_q == ST_ADDR && scl_fall && byte_done) begin
        dir_q        <= shift_q[0];
        alert_resp_q <= ar_hit & ~addr_hit;
      end
      if (start_det || stop_det) begin
        sda_oe_q <= 1'b0;
      end else if (scl_fall && byte_done && state_q != ST_TX) begin
        sda_oe_q <= (state_q == ST_ADDR) ? addr_ack : (state_q inside {ST_CMD, ST_WDATA});
      end else if (read_start) begin
        sda_oe_q <= ~tx_byte[7];
      end else if (state_q == ST_TX && scl_fall) begin
        sda_oe_q <= byte_done ? 1'b0 : ~shift_q[6];
      end else if (scl_fall) begin
        sda_oe_q <= 1'b0;
      end
    end
  end

  // Pointer and pending one-shot commands.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pointer_q    <= POINTER_RESET;
      pend_rap_q   <= 1'b0;
      pend_reset_q <= 1'b0;
    end else begin
      if (cmd_ack_end) begin
        pointer_q    <= shift_q;
        pend_rap_q   <= (shift_q == CMD_RESAMPLE_ADDR);
        pend_reset_q <= (shift_q == CMD_SOFT_RESET);
      end else if (cmd_fire || start_det || stop_det) begin
        pend_rap_q   <= 1'b0;
        pend_reset_q <= 1'b0;
      end
    end
  end

  // Strap sampling runs a short delay after reset release or on command, so
  // that the synchronised strap levels are settled when they are adopted.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      samp_cnt_q <= SAMPLE_DELAY;
      own_addr_q <= 7'h00;
    end else begin
      if (fire_rap || fire_rst) begin
        samp_cnt_q <= SAMPLE_DELAY;
      end else if (samp_cnt_q != 2'h0) begin
        samp_cnt_q <= samp_cnt_q - 2'h1;
      end
      if (samp_cnt_q == 2'h1) begin
        own_addr_q <= addr_calc;
      end
    end
  end

  // Write target: anything but the six data registers lands in normal drive.
  wire wr_n_rise = data_ack_end & (pointer_q == CMD_NORMAL_RISE);
  wire wr_n_fall = data_ack_end & (pointer_q == CMD_NORMAL_FALL);
  wire wr_s_drv  = data_ack_end & (pointer_q == CMD_SUSPEND_DRIVE);
  wire wr_s_rise = data_ack_end & (pointer_q == CMD_SUSPEND_RISE);
  wire wr_s_fall = data_ack_end & (pointer_q == CMD_SUSPEND_FALL);
  wire wr_n_drv  = data_ack_end & ~(wr_n_rise | wr_n_fall | wr_s_drv | wr_s_rise | wr_s_fall);

  // Register sets; a soft reset restores them and the data byte then wins.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      normal_q  <= SET_RESET;
      suspend_q <= SET_RESET;
    end else begin
      if (fire_rst) begin
        normal_q  <= SET_RESET;
        suspend_q <= SET_RESET;
      end
      if (wr_n_drv) normal_q.drive <= shift_q;
      if (wr_n_rise) normal_q.rise_mask <= shift_q;
      if (wr_n_fall) normal_q.fall_mask <= shift_q;
      if (wr_s_drv) suspend_q.drive <= shift_q;
      if (wr_s_rise) suspend_q.rise_mask <= shift_q;
      if (wr_s_fall) suspend_q.fall_mask <= shift_q;
    end
  end

  // Pin readback and alert latch; a new edge wins over a clear.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      readback_q <= 8'h00;
      alert_q    <= 1'b0;
    end else begin
      if (read_start) begin
        readback_q <= io_s2;
      end
      if (|(io_rise | io_fall)) begin
        alert_q <= 1'b1;
      end else if (fire_rst || (read_start && alert_resp_q)) begin
        alert_q <= 1'b0;
      end
    end
  end

  // Open-drain pins only ever pull low; the enable carries the information.
  // pin drive
  assign IO_OE        = ~act_set.drive;
  assign IO_OUT       = 8'h00;
  assign SMB_DATA_OUT = 1'b0;
  assign SMB_DATA_OE  = sda_oe_q;
  assign ALERT_N_OUT  = 1'b0;
  assign ALERT_N_OE   = alert_q;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_addr_byte_ok;
    (state_q == ST_ADDR) && scl_fall && byte_done && addr_ack;
  endsequence

  sequence s_resample_run;
    (samp_cnt_q == 2'h3) ##2 (samp_cnt_q == 2'h1);
  endsequence

  AST_SET_SELECT: assert property (
    $changed(sus_s2) |-> IO_OE == ~(sus_s2 ? normal_q.drive : suspend_q.drive))
    else $error("applied drive does not follow suspend select");
  AST_SOFT_RESET_CMD_DRIVE: assert property (
    fire_rst && !data_ack_end |=> normal_q.drive == DRIVE_RESET && suspend_q.drive == DRIVE_RESET)
    else $error("soft reset did not restore drive registers");
  AST_SOFT_RESET_CMD_MASKS: assert property (
    fire_rst && !data_ack_end |=> normal_q.rise_mask == MASK_RESET && suspend_q.fall_mask == MASK_RESET)
    else $error("soft reset did not mask interrupts");
  AST_READBACK: assert property (
    read_start |=> readback_q == $past(io_s2))
    else $error("readback not captured at read acknowledge end");
  AST_REDIRECT: assert property (
    data_ack_end && (pointer_q >= CMD_READBACK) |=> normal_q.drive == $past(shift_q))
    else $error("write to read-only entry not redirected");
  AST_ADDR_ACK: assert property (
    s_addr_byte_ok |=> sda_oe_q && (state_q == ST_ADDR_ACK))
    else $error("matching address not acknowledged");
  AST_POINTER_KEEP: assert property (
    fire_rst && !cmd_ack_end |=> $stable(pointer_q))
    else $error("soft reset altered the register pointer");
  AST_RESAMPLE: assert property (
    fire_rap |=> s_resample_run)
    else $error("resample command did not restart strap sampling");
  AST_ALERT_SET: assert property (
    |(io_rise | io_fall) |=> alert_q ##1 (alert_q || $past(fire_rst || read_start)))
    else $error("unmasked edge did not raise alert");
  AST_TX_MSB: assert property (
    read_start |=> sda_oe_q == ~$past(tx_byte[7]))
    else $error("reply does not start with its top bit");

endmodule : smbus_io_expander_regs

`default_nettype wire

/* verification/smbus_host.sv */
// Behavioural two-wire bus master that drives the expander's clock and data lines.
`timescale 1ns/10ps
`default_nettype none

module smbus_host (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  logic in_frame;

  // Both lines rest released, so the clock stands high between frames.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    in_frame = 1'b0;
  end

  task automatic start();
    if (in_frame) begin
      scl = 1'b0;
      #100 sda_pull = 1'b0;
      #300 scl = 1'b1;
      #400;
    end
    sda_pull = 1'b1;
    #400 in_frame = 1'b1;
  endtask : start

  task automatic stop();
    scl = 1'b0;
    #100 sda_pull = 1'b1;
    #300 scl = 1'b1;
    #400 sda_pull = 1'b0;
    #800 in_frame = 1'b0;
  endtask : stop

  // Eight bits high first, then a released ninth bit.
  // Data moves only while the clock is low and is sampled mid high phase.
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      scl = 1'b0;
      #100 sda_pull = (i > 0) ? ~tx[i-1] : 1'b0;
      #300 scl = 1'b1;
      #200;
      if (i > 0) rx[i-1] = sda;
      else ack = sda;
      #200;
    end
  endtask : xbyte
endmodule : smbus_host
`default_nettype wire

/* verification/smbus_io_expander_regs_tb_top.sv */
// Self-checking bench for the two-wire I/O expander register file.
`timescale 1ns/10ps
`default_nettype none

module smbus_io_expander_regs_tb_top
  import ioexp_pkg::*;
;
  localparam logic [7:0] ID     = 8'h3e;  // Arbitrary identification value.
  localparam logic [6:0] ADDR_A = 7'h24;
  localparam logic [6:0] ADDR_B = 7'h26;

  logic       core_clk;
  logic       rst;
  logic       scl;
  logic       pull;
  wire        sda;
  logic       oe;
  logic       dout;
  logic [7:0] io_oe;
  logic [7:0] io_out;
  logic [7:0] ext;
  wire  [7:0] io_level;
  logic       sel;
  logic [1:0] strap1;
  logic       alert_oe;
  logic       alert_out;
  logic [7:0] rx;
  logic       acks;
  int         errors;
  int         checked;

  // Open-drain wires with pull-ups; a pin released by the device shows the outside level.
  assign sda = (oe ? dout : 1'b1) & ~pull;
  assign io_level = (io_oe & io_out) | (~io_oe & ext);

  smbus_io_expander_regs #(.RESET_RELEASED(1'b1), .MAKER_ID(ID)) u_dut (
    .CORE_CLK(core_clk), .RST(rst), .SMB_CLK(scl), .SMB_DATA_IN(sda),
    .SMB_DATA_OUT(dout), .SMB_DATA_OE(oe), .IO_IN(io_level), .IO_OUT(io_out),
    .IO_OE(io_oe), .SUSPEND_SELECT(sel), .ADDR_STRAP0(STRAP_GND),
    .ADDR_STRAP1(strap1), .ALERT_N_OUT(alert_out), .ALERT_N_OE(alert_oe)
  );

  smbus_host u_host (.scl(scl), .sda_pull(pull), .sda(sda));

  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // Changes pin-side inputs just after an edge, then lets the synchronisers settle.
  task automatic set_pins(input logic s, input logic [7:0] e, input logic [1:0] st);
    @(posedge core_clk);
    #1;
    sel = s;
    ext = e;
    strap1 = st;
    repeat (10) @(posedge core_clk);
    #1;
  endtask : set_pins

  // Mode 0 write-byte, 1 send-byte, 2 read-byte, 3 receive-byte; acks gathers slave acks.
  task automatic xfer(input int mode, input logic [6:0] a, input logic [7:0] c,
                      input logic [7:0] d);
    logic [7:0] r;
    logic       k;
    @(posedge core_clk);
    #1;
    u_host.start();
    u_host.xbyte({a, mode == 3}, r, k);
    acks = k;
    if (mode < 3) begin
      u_host.xbyte(c, r, k);
      acks = acks | k;
    end
    if (mode == 0) begin
      u_host.xbyte(d, r, k);
      acks = acks | k;
    end
    if (mode == 2) begin
      u_host.start();
      u_host.xbyte({a, 1'b1}, r, k);
      acks = acks | k;
    end
    if (mode >= 2) u_host.xbyte(8'hff, rx, k);
    u_host.stop();
  endtask : xfer

  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    #5000000;
    errors++;
    print_verdict();
  end

  // Main sequence of bus transfers and pin changes.
  initial begin
    rst = 1'b1;
    sel = 1'b1;
    ext = 8'h00;
    strap1 = STRAP_GND;
    rx = 8'h00;
    acks = 1'b0;
    errors = 0;
    checked = 0;
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (10) @(posedge core_clk);
    chk("io_oe", 8'h00, io_oe);
    xfer(3, ADDR_A, 8'h00, 8'h00);
    chk("pointer", 8'hff, rx);
    set_pins(1'b1, 8'hff, STRAP_GND);
    chk("alert", 8'h00, {7'h0, alert_oe});
    for (int i = 0; i < 6; i++) begin
      xfer(2, ADDR_A, 8'(i), 8'h00);
      chk("por", 8'hff, rx);
    end
    xfer(0, 7'h25, 8'h00, 8'h00);
    chk("nack", 8'h01, {7'h0, acks});
    for (int i = 0; i < 6; i++) begin
      xfer(0, ADDR_A, 8'(i), 8'h81 + 8'(i) * 8'h12);
      xfer(2, ADDR_A, 8'(i), 8'h00);
      chk("ack", 8'h00, {7'h0, acks});
      chk("reg", 8'h81 + 8'(i) * 8'h12, rx);
    end
    set_pins(1'b1, 8'hff, STRAP_GND);
    chk("io_oe", ~8'h81, io_oe);
    set_pins(1'b0, 8'hff, STRAP_GND);
    chk("io_oe", ~8'hb7, io_oe);
    set_pins(1'b1, 8'h0f, STRAP_GND);
    xfer(2, ADDR_A, CMD_READBACK, 8'h00);
    chk("readback", 8'h01, rx);
    set_pins(1'b1, 8'hff, STRAP_GND);
    xfer(3, ADDR_A, 8'h00, 8'h00);
    chk("readback", 8'h81, rx);
    xfer(0, ADDR_A, CMD_READBACK, 8'h5a);
    xfer(2, ADDR_A, CMD_NORMAL_DRIVE, 8'h00);
    chk("drive", 8'h5a, rx);
    xfer(0, ADDR_A, CMD_MAKER_ID, 8'h66);
    xfer(2, ADDR_A, CMD_NORMAL_DRIVE, 8'h00);
    chk("drive", 8'h66, rx);
    xfer(2, ADDR_A, CMD_MAKER_ID, 8'h00);
    chk("maker_id", ID, rx);
    set_pins(1'b1, 8'hff, STRAP_VCC);
    xfer(1, ADDR_A, CMD_RESAMPLE_ADDR, 8'h00);
    xfer(2, ADDR_B, CMD_NORMAL_DRIVE, 8'h00);
    chk("ack", 8'h00, {7'h0, acks});
    xfer(2, ADDR_A, CMD_NORMAL_DRIVE, 8'h00);
    chk("nack", 8'h01, {7'h0, acks});
    set_pins(1'b1, 8'hff, STRAP_GND);
    xfer(0, ADDR_B, CMD_RESAMPLE_ADDR, 8'h44);
    xfer(2, ADDR_A, CMD_NORMAL_DRIVE, 8'h00);
    chk("ack", 8'h00, {7'h0, acks});
    chk("drive", 8'h44, rx);
    xfer(1, ADDR_A, CMD_SOFT_RESET, 8'h00);
    xfer(3, ADDR_A, 8'h00, 8'h00);
    chk("pointer", 8'h00, rx);
    xfer(2, ADDR_A, CMD_NORMAL_RISE, 8'h00);
    chk("rise", 8'hff, rx);
    xfer(2, ADDR_A, CMD_NORMAL_DRIVE, 8'h00);
    chk("drive", 8'hff, rx);
    xfer(0, ADDR_A, CMD_NORMAL_FALL, 8'h00);
    xfer(0, ADDR_A, CMD_SOFT_RESET, 8'h12);
    xfer(2, ADDR_A, CMD_NORMAL_FALL, 8'h00);
    chk("fall", 8'hff, rx);
    xfer(2, ADDR_A, CMD_NORMAL_DRIVE, 8'h00);
    chk("drive", 8'h12, rx);
    xfer(0, ADDR_A, CMD_NORMAL_DRIVE, 8'hff);
    xfer(0, ADDR_A, CMD_NORMAL_RISE, 8'hfe);
    set_pins(1'b1, 8'h00, STRAP_GND);
    chk("alert", 8'h00, {7'h0, alert_oe});
    set_pins(1'b1, 8'h01, STRAP_GND);
    chk("alert", 8'h01, {6'h0, alert_out, alert_oe});
    xfer(3, ALERT_RESPONSE_ADDR, 8'h00, 8'h00);
    chk("alert_addr", {ADDR_A, 1'b0}, rx);
    chk("alert", 8'h00, {6'h0, alert_out, alert_oe});
    print_verdict();
  end
endmodule : smbus_io_expander_regs_tb_top
`default_nettype wire
